// file: hdl/ramp_time_selector.sv
// Ramp time pair selection, option decode and regulation gating
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// (R01) Option A: 1 off, 2 ramp, 3 pattern, 4 traverse
// (R02) Option B: 1 off, 2 PID, 3 pump
// (R03) Software enables one option at a time
// (R04) Program select runs eight speeds with ramp pairs
// (R05) Without program select, ramps still follow inputs
// (R06) Binary mode: low three steps index pair
// (R07) Direct mode: one-hot step plus bank bit
// (R08) Direct mode all off holds latest pair
// (R09) Held selection clears to zero at reset
// (R10) Enable input gates loop regulation
// (R11) Regulation only when local indicator off
// (R12) Regulation only under forward or reverse run
// (R13) Overcurrent limit percent, default 150
// (R14) Overcurrent limit always active; the enable output is held low while reset is asserted
// (R15) Direct mode several active holds selection
module ramp_time_selector
    import ramp_sel_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequence inputs from pins
    input wire logic [9:0] seq_pins,
    // Results
    output logic [IDX_W-1:0] pair_index_q,
    output logic [RAMP_W-1:0] accel_time_q,
    output logic [RAMP_W-1:0] decel_time_q,
    output logic program_speed_active_q,
    output logic [IDX_W-1:0] speed_index_q,
    output logic regulation_active_q,
    output logic [15:0] overcurrent_limit_level_q,
    output logic overcurrent_limit_enable_q,
    output logic [2:0] active_option_q
);
    // Input synchroniser
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    seq_in_s seq;

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= seq_pins;
            sync2_q <= sync1_q;
        end
    end
    assign seq = seq_in_s'(sync2_q);

    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] ocl_q;
    wire [2:0] option_select_a = ctrl_q[CTRL_OPTA_LSB +: 3];
    wire [2:0] option_select_b = ctrl_q[CTRL_OPTB_LSB +: 3];
    wire [1:0] selection_mode_setting = ctrl_q[CTRL_MODE_LSB +: 2];

    // APB decode
    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite;
    wire apb_rd_setup = psel && !penable && !pwrite;
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_ocl = (paddr == ADDR_OCL);
    wire hit_stat = (paddr == ADDR_STATUS);
    // Table spans sixteen words from its base, accel first then decel
    wire [31:0] ramp_off = paddr - ADDR_RAMP_BASE;
    wire hit_ramp = (paddr >= ADDR_RAMP_BASE) && (ramp_off[31:6] == '0) &&
                    (ramp_off[1:0] == 2'b00);
    wire [3:0] ramp_addr = ramp_off[5:2];
    wire hit_any = hit_ctrl || hit_ocl || hit_stat || hit_ramp;
    wire [RAMP_W-1:0] mem_rd_data;

    // Reads of memory data take two cycles, register reads answer at once
    logic rd_wait_q;
    wire slow_rd = apb_rd_setup && hit_ramp;
    wire ramp_wr = apb_wr && hit_ramp && pready;

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= slow_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
            ocl_q <= OCL_DEFAULT; // R13
        end else if (apb_wr && pready) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata & 32'h0000_0377;
            end else if (hit_ocl) begin
                ocl_q <= pwdata[15:0]; // R13
            end
        end
    end

    wire [31:0] status_word = {16'h0000, 5'h00, regulation_active_q,
                               program_speed_active_q, active_option_q,
                               speed_index_q, pair_index_q};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                         hit_ocl ? {16'h0000, ocl_q} :
                         hit_stat ? status_word :
                         hit_ramp ? {16'h0000, mem_rd_data} : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= (psel && !penable && !slow_rd) || rd_wait_q;
            pslverr <= ((psel && !penable && !slow_rd) || rd_wait_q) &&
                       !hit_any;
            prdata <= (rd_wait_q || (apb_rd_setup && !slow_rd)) ?
                      rd_mux : 32'h0000_0000;
            if (pready) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    ramp_table_mem u_mem (
        .clk(clk),
        .reset(reset),
        .wr_en(ramp_wr),
        .wr_addr(ramp_addr),
        .wr_data(pwdata[RAMP_W-1:0]),
        .rd_addr(ramp_addr),
        .rd_data(mem_rd_data),
        .pair_idx(pair_index_q),
        .accel_q(accel_time_q),
        .decel_q(decel_time_q)
    );

    // Option decode; option A wins if both are set
    option_e opt;
    assign opt = (option_select_a == OPT_A_RAMP) ? FN_RAMP : // R01
                 (option_select_a == OPT_A_PATTERN) ? FN_PATTERN : // R01
                 (option_select_a == OPT_A_TRAVERSE) ? FN_TRAVERSE : // R01
                 (option_select_b == OPT_B_PID) ? FN_PID : // R02
                 (option_select_b == OPT_B_PUMP) ? FN_PUMP : // R02
                 FN_NONE; // R03

    // Step selection
    wire [3:0] steps = {seq.step_select_3, seq.step_select_2,
                        seq.step_select_1, seq.step_select_0};
    wire [IDX_W-1:0] binary_idx = steps[2:0]; // R06
    wire one_hot = (steps != 4'h0) && ((steps & (steps - 4'h1)) == 4'h0);
    wire [1:0] hot_pos = steps[3] ? 2'h3 : steps[2] ? 2'h2 :
                         steps[1] ? 2'h1 : 2'h0;
    wire [IDX_W-1:0] direct_idx = {seq.step_bank_select, hot_pos}; // R07
    logic [IDX_W-1:0] idx_d;

    always_comb begin
        idx_d = pair_index_q;
        if (selection_mode_setting == MODE_BINARY) begin
            idx_d = binary_idx; // R06
        end else if (selection_mode_setting == MODE_DIRECT) begin
            if (one_hot) begin
                idx_d = direct_idx; // R07
            end else begin
                idx_d = pair_index_q; // R08 R15
            end
        end
    end

    // Ramp pair follows steps whether program select is on or not
    always_ff @(posedge clk) begin
        if (reset) begin
            pair_index_q <= IDX_RESET; // R09
            speed_index_q <= IDX_RESET;
            program_speed_active_q <= 1'b0;
        end else begin
            pair_index_q <= idx_d; // R05
            program_speed_active_q <= seq.program_speed_select; // R04
            if (seq.program_speed_select) begin
                speed_index_q <= idx_d; // R04
            end
        end
    end

    // Regulation gating and option outputs
    wire run_cmd = seq.forward_run_command || seq.reverse_run_command;
    wire reg_ok = ((opt == FN_PID) || (opt == FN_PUMP)) &&
                  seq.loop_regulation_enable && // R10
                  !seq.local_operation_indicator && // R11
                  run_cmd; // R12

    always_ff @(posedge clk) begin
        if (reset) begin
            regulation_active_q <= 1'b0;
            active_option_q <= 3'h0;
            overcurrent_limit_level_q <= OCL_DEFAULT;
            overcurrent_limit_enable_q <= 1'b0;
        end else begin
            regulation_active_q <= reg_ok;
            active_option_q <= opt;
            overcurrent_limit_level_q <= ocl_q; // R13
            overcurrent_limit_enable_q <= 1'b1; // R14
        end
    end

    // Checks
    a_binary_index: assert property (@(posedge clk) // R06
        disable iff (reset)
        (selection_mode_setting == MODE_BINARY) |=>
        pair_index_q == $past(steps[2:0]))
        else $error("binary index wrong");
    a_direct_select: assert property (@(posedge clk) // R07
        disable iff (reset)
        (selection_mode_setting == MODE_DIRECT && one_hot) |=>
        pair_index_q == $past(direct_idx))
        else $error("direct select wrong");
    a_hold_none: assert property (@(posedge clk) // R08
        disable iff (reset)
        (selection_mode_setting == MODE_DIRECT && steps == 4'h0) |=>
        $stable(pair_index_q))
        else $error("hold not kept");
    a_hold_multi: assert property (@(posedge clk) // R15
        disable iff (reset)
        (selection_mode_setting == MODE_DIRECT && steps != 4'h0 &&
         !one_hot) |=> $stable(pair_index_q))
        else $error("multi step changed pair");
    a_reset_clear: assert property (@(posedge clk) // R09
        reset |=> pair_index_q == IDX_RESET)
        else $error("held pair not cleared");
    a_reg_local: assert property (@(posedge clk) // R11
        disable iff (reset)
        seq.local_operation_indicator |=> !regulation_active_q)
        else $error("regulation in local mode");
    a_reg_run: assert property (@(posedge clk) // R12
        disable iff (reset)
        !run_cmd |=> !regulation_active_q)
        else $error("regulation without run");
    a_reg_enable: assert property (@(posedge clk) // R10
        disable iff (reset)
        !seq.loop_regulation_enable |=> !regulation_active_q)
        else $error("regulation not gated");
    a_ocl_on: assert property (@(posedge clk) // R14
        disable iff (reset)
        !reset |=> overcurrent_limit_enable_q)
        else $error("overcurrent limit off");
    a_ocl_level: assert property (@(posedge clk) // R13
        disable iff (reset)
        1'b1 |=> overcurrent_limit_level_q == $past(ocl_q))
        else $error("overcurrent level wrong");
    a_opt_ramp: assert property (@(posedge clk) // R01
        disable iff (reset)
        (option_select_a == OPT_A_RAMP) |=> active_option_q == FN_RAMP)
        else $error("option decode wrong");
    a_opt_pid: assert property (@(posedge clk) // R02
        disable iff (reset)
        (option_select_a == OPT_A_OFF && option_select_b == OPT_B_PID)
        |=> active_option_q == FN_PID)
        else $error("pid decode wrong");
    a_opt_none: assert property (@(posedge clk) // R01
        disable iff (reset)
        (option_select_a == OPT_A_OFF && option_select_b == OPT_B_OFF)
        |=> active_option_q == FN_NONE)
        else $error("no option decode wrong");
    a_speed_follow: assert property (@(posedge clk) // R04
        disable iff (reset)
        seq.program_speed_select |=> speed_index_q == pair_index_q)
        else $error("speed index not following");
    a_speed_hold: assert property (@(posedge clk) // R05
        disable iff (reset)
        !seq.program_speed_select |=> $stable(speed_index_q))
        else $error("speed index moved");

    c_multi_hold: cover property (@(posedge clk) disable iff (reset)
        selection_mode_setting == MODE_DIRECT && steps != 4'h0 && !one_hot);

    c_direct_hold: cover property (@(posedge clk) disable iff (reset)
        selection_mode_setting == MODE_DIRECT && one_hot ##1 steps == 4'h0);
    c_bank_high: cover property (@(posedge clk) disable iff (reset)
        pair_index_q == 3'h7);
    c_regulate: cover property (@(posedge clk) disable iff (reset)
        regulation_active_q);
endmodule : ramp_time_selector
`default_nettype wire

// file: hdl/ramp_sel_pkg.sv
// Package with constants and types for the ramp time selector
package ramp_sel_pkg;
    localparam int RAMP_W = 16;
    localparam int PAIRS = 8;
    localparam int IDX_W = 3;
    localparam logic [2:0] OPT_A_OFF = 3'h1;
    localparam logic [2:0] OPT_A_RAMP = 3'h2;
    localparam logic [2:0] OPT_A_PATTERN = 3'h3;
    localparam logic [2:0] OPT_A_TRAVERSE = 3'h4;
    localparam logic [2:0] OPT_B_OFF = 3'h1;
    localparam logic [2:0] OPT_B_PID = 3'h2;
    localparam logic [2:0] OPT_B_PUMP = 3'h3;
    localparam logic [1:0] MODE_BINARY = 2'h1;
    localparam logic [1:0] MODE_DIRECT = 2'h2;
    localparam logic [15:0] OCL_DEFAULT = 16'h0096;
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_OCL = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam logic [31:0] ADDR_RAMP_BASE = 32'h0000_0010;
    localparam int CTRL_OPTA_LSB = 0;
    localparam int CTRL_OPTB_LSB = 4;
    localparam int CTRL_MODE_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0111;

    typedef enum logic [2:0] {
        FN_NONE, FN_RAMP, FN_PATTERN, FN_TRAVERSE, FN_PID, FN_PUMP
    } option_e;

    typedef struct packed {
        logic program_speed_select;
        logic step_bank_select;
        logic step_select_3;
        logic step_select_2;
        logic step_select_1;
        logic step_select_0;
        logic loop_regulation_enable;
        logic forward_run_command;
        logic reverse_run_command;
        logic local_operation_indicator;
    } seq_in_s;
endpackage : ramp_sel_pkg

// file: hdl/ramp_table_mem.sv
// Small memory holding the acceleration and deceleration ramp times
`timescale 1ns/10ps
`default_nettype none
module ramp_table_mem
    import ramp_sel_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [RAMP_W-1:0] wr_data,
    // Read port A, entries 0..15
    input wire logic [3:0] rd_addr,
    output logic [RAMP_W-1:0] rd_data,
    // Selected pair read port
    input wire logic [IDX_W-1:0] pair_idx,
    output logic [RAMP_W-1:0] accel_q,
    output logic [RAMP_W-1:0] decel_q
);
    logic [RAMP_W-1:0] mem_q [0:2*PAIRS-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= '0;
            accel_q <= '0;
            decel_q <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
            accel_q <= mem_q[{1'b0, pair_idx}];
            decel_q <= mem_q[{1'b1, pair_idx}];
        end
    end
endmodule : ramp_table_mem
`default_nettype wire

// file: bench/seq_pin_drv.sv
// Model of the digital sequence input pins feeding the selector
`timescale 1ns/10ps
`default_nettype none
module seq_pin_drv
    import ramp_sel_pkg::*;
(
    // Clock
    input wire logic clk,
    // Commanded levels
    input wire seq_in_s cmd,
    // Pin levels
    output var logic [9:0] seq_pins
);
    initial seq_pins = 10'h000;
    // Contacts change just after a rising edge of the same clock that samples them
    always @(posedge clk) begin
        seq_pins <= cmd;
    end
endmodule : seq_pin_drv
`default_nettype wire

// file: bench/tb_ramp_time_selector.sv
// Testbench for the ramp time selector
`timescale 1ns/10ps
`default_nettype none
module tb_ramp_time_selector
    import ramp_sel_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, err;
    logic [9:0] seq_pins;
    seq_in_s pins = 10'h000;
    logic [2:0] pair_index_q, speed_index_q, active_option_q;
    logic [15:0] accel_time_q, decel_time_q, overcurrent_limit_level_q;
    logic program_speed_active_q, regulation_active_q;
    logic overcurrent_limit_enable_q;
    int n_errors = 0;
    int checked = 0;
    logic [2:0] a_exp [4] = '{FN_NONE, FN_RAMP, FN_PATTERN, FN_TRAVERSE};
    logic [2:0] b_exp [3] = '{FN_NONE, FN_PID, FN_PUMP};
    // Expected flag, then enable, forward, reverse, local
    logic [4:0] reg_case [5] = '{5'h1C, 5'h1A, 5'h0D, 5'h04, 5'h08};

    ramp_time_selector dut_u (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seq_pins(seq_pins), .pair_index_q(pair_index_q),
        .accel_time_q(accel_time_q), .decel_time_q(decel_time_q),
        .program_speed_active_q(program_speed_active_q),
        .speed_index_q(speed_index_q),
        .regulation_active_q(regulation_active_q),
        .overcurrent_limit_level_q(overcurrent_limit_level_q),
        .overcurrent_limit_enable_q(overcurrent_limit_enable_q),
        .active_option_q(active_option_q));

    seq_pin_drv pin_u (.clk(clk), .cmd(pins), .seq_pins(seq_pins));

    always #50 clk = ~clk;

    task end_sim();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, entered and left just after a rising edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: no pready", $time);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rd_chk

    // Two sync flops, output register, then table read
    task settle();
        repeat (6) @(posedge clk);
    endtask : settle

    function automatic logic [31:0] ctl(input logic [2:0] a,
        input logic [2:0] b, input logic [1:0] m);
        return {22'h0, m, 1'b0, b, 1'b0, a};
    endfunction : ctl

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk(ADDR_STATUS, 32'h0000_0000);
        rd_chk(ADDR_OCL, {16'h0000, OCL_DEFAULT});
        rd_chk(ADDR_CTRL, CTRL_RESET);
        chk({31'h0, overcurrent_limit_enable_q}, 32'h0000_0001);
        apb(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rdat, 32'h0000_0000);
        wr(ADDR_CTRL, 32'hFFFF_FFFF);
        rd_chk(ADDR_CTRL, 32'h0000_0377);
        wr(ADDR_OCL, 32'h0000_0078);
        rd_chk(ADDR_OCL, 32'h0000_0078);
        chk({16'h0, overcurrent_limit_level_q}, 32'h0000_0078);
        chk({31'h0, overcurrent_limit_enable_q}, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_RAMP_BASE + 32'(4 * i), 32'h0000_0100 + 32'(i));
            wr(ADDR_RAMP_BASE + 32'(32 + 4 * i), 32'h0000_0200 + 32'(i));
        end
        rd_chk(ADDR_RAMP_BASE + 32'h0000_0024, 32'h0000_0201);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, ctl(3'(i + 1), 3'h1, MODE_BINARY));
            @(posedge clk);
            chk({29'h0, active_option_q}, {29'h0, a_exp[i]});
        end
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, ctl(3'h1, 3'(i + 1), MODE_BINARY));
            @(posedge clk);
            chk({29'h0, active_option_q}, {29'h0, b_exp[i]});
        end
        wr(ADDR_CTRL, ctl(OPT_A_OFF, OPT_B_PID, MODE_BINARY));
        for (int i = 0; i < 5; i++) begin
            pins[3:0] <= reg_case[i][3:0];
            settle();
            chk({31'h0, regulation_active_q}, {31'h0, reg_case[i][4]});
        end
        for (int i = 0; i < 8; i++) begin
            pins[9:4] <= {1'b1, i[0], ~i[0], 3'(i)};
            settle();
            chk({29'h0, pair_index_q}, 32'(i));
            chk({16'h0, accel_time_q}, 32'h0000_0100 + 32'(i));
            chk({16'h0, decel_time_q}, 32'h0000_0200 + 32'(i));
            chk({29'h0, speed_index_q}, 32'(i));
            chk({31'h0, program_speed_active_q}, 32'h0000_0001);
        end
        wr(ADDR_CTRL, ctl(OPT_A_OFF, OPT_B_OFF, MODE_DIRECT));
        for (int i = 0; i < 8; i++) begin
            pins[9:4] <= {1'b0, i[2], 4'b0001 << i[1:0]};
            settle();
            chk({29'h0, pair_index_q}, 32'(i));
            chk({16'h0, decel_time_q}, 32'h0000_0200 + 32'(i));
            chk({29'h0, speed_index_q}, 32'h0000_0007);
            chk({31'h0, program_speed_active_q}, 32'h0000_0000);
        end
        pins[9:4] <= 6'h00;
        settle();
        chk({29'h0, pair_index_q}, 32'h0000_0007);
        pins[9:4] <= 6'h13;
        settle();
        chk({29'h0, pair_index_q}, 32'h0000_0007);
        chk({16'h0, accel_time_q}, 32'h0000_0107);
        rd_chk(ADDR_STATUS, 32'h0000_003F);
        end_sim();
    end

    initial begin
        #1_000_000;
        n_errors++;
        end_sim();
    end
endmodule : tb_ramp_time_selector
`default_nettype wire
